// file: hw/odt_device.sv
// Device end: on-die termination control with dynamic write strength
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - One pin terminates all 38 data lanes
// - All-zero nominal and write bits disable termination
// - Pin low off; high on unless disabled
// - Self-refresh ignores pin, termination off
// - On/off follows pin only, no decode
// - Synchronous timing whenever loop runs locked
// - Controller keeps termination off with loop off
// - Switch on/off a latency after pin registered
// - Latency is write plus additive minus two
// - Controller holds pin high four clocks
// - After write, hold four or six clocks
// - Controller drops pin around reads
// - Termination returns when device stops driving
// - Dynamic switching enabled by write-value bits
// - Nominal and write values from mode bits
// - Nominal strength outside writes, pin-timed
// - Write strength at write latency minus two
// - Nominal again four/six plus turn-off latency
// - Controller zeroes write bits of MRS during loop off
// - Frozen-loop mode skips additive latency on the pin path; the write window keeps it
module odt_device (
	input wire logic core_clk,
	input wire logic arst_n,
	odt_link_if.device link,
	input wire logic rd_drive,
	output odt_pkg::odt_rtt_type rtt_sel,
	output logic [odt_pkg::TERM_LANES-1:0] term_lane,
	output logic [2:0] rtt_nom_code,
	output logic [1:0] rtt_wr_code,
	output logic sync_mode,
	output logic dyn_en
);
	import odt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Latency decode, shared by on/off and write-window paths
	function automatic logic [4:0] odt_latency(input logic [15:0] mr0, input logic [15:0] mr1,
		input logic [15:0] mr2, input logic use_al);
		logic [4:0] cwl;
		logic [4:0] cl;
		logic [4:0] al;
		cwl = CWL_BASE + {2'b00, mr2[MR2_CWL_LO +: 3]};
		cl = CL_BASE + {2'b00, mr0[MR0_CL_LO +: 3]};
		case (mr1[MR1_AL_LO +: 2])
			2'b01: al = cl - 5'h01;
			2'b10: al = cl - 5'h02;
			default: al = 5'h00;
		endcase
		if (!use_al) begin
			al = 5'h00;
		end
		odt_latency = cwl + al - ODT_LAT_SUB;
	endfunction : odt_latency

	////////////////////////////////////////////////////////////////////////////
	// Mode registers, loaded by mode register set
	logic [15:0] mr0;
	logic [15:0] mr1;
	logic [15:0] mr2;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mr0 <= MR_RESET;
			mr1 <= MR_RESET;
			mr2 <= MR_RESET;
		end else if (link.mrs_valid) begin
			if (link.mrs_sel == MR_SEL_0) begin
				mr0 <= link.mrs_addr;
			end
			if (link.mrs_sel == MR_SEL_1) begin
				mr1 <= link.mrs_addr;
			end
			if (link.mrs_sel == MR_SEL_2) begin
				mr2 <= link.mrs_addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire logic [2:0] nom_code = {mr1[MR1_NOM_B2], mr1[MR1_NOM_B1], mr1[MR1_NOM_B0]};
	wire logic [1:0] wr_code = mr2[MR2_WR_HI:MR2_WR_LO];
	wire logic odt_enabled = (nom_code != 3'h0) || (wr_code != 2'h0);
	wire logic dyn_on = (wr_code != 2'h0);
	// Loop frozen only in precharge power-down with the slow-exit setting
	wire logic loop_frozen = !link.cke && !link.sref && !mr0[MR0_DLL_PD_BIT];
	wire logic sync_now = !loop_frozen;
	// Frozen mode drops the additive latency from the pin path
	wire logic [4:0] pin_lat = odt_latency(mr0, mr1, mr2, sync_now);
	wire logic [4:0] wr_lat = odt_latency(mr0, mr1, mr2, 1'b1);

	////////////////////////////////////////////////////////////////////////////
	// Pin path: sampled pin delayed by the turn-on/turn-off latency
	logic pin_late;

	odt_delay_line u_pin_delay (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.din(link.odt),
		.tap(pin_lat - 5'h01),
		.dout(pin_late)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write window: counts clocks since the last registered write
	logic [5:0] wr_cnt;
	logic wr_active;
	logic wr_bc4;
	wire logic [5:0] cnw_at = {1'b0, wr_lat};
	wire logic [5:0] cwn_at = {1'b0, wr_lat} + {1'b0, (wr_bc4 ? CWN4_EXTRA : CWN8_EXTRA)};
	wire logic [5:0] next_wr_cnt = (wr_cnt == WR_CNT_MAX) ? wr_cnt : wr_cnt + 6'h01;
	wire logic in_wr_window = wr_active && (wr_cnt >= cnw_at) && (wr_cnt < cwn_at);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_cnt <= 6'h00;
			wr_active <= 1'b0;
			wr_bc4 <= 1'b0;
		end else if (link.wr_cmd) begin
			// A newer write restarts the window; every write variant counts
			wr_cnt <= 6'h01;
			wr_active <= 1'b1;
			wr_bc4 <= link.wr_bc4;
		end else begin
			wr_cnt <= next_wr_cnt;
			if (wr_cnt >= cwn_at) begin
				wr_active <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strength selection
	logic term_state;
	wire logic term_allowed = pin_late && odt_enabled && !link.sref;
	// Device output drive has priority; release follows drive end directly
	wire logic term_gate = term_allowed && !rd_drive;
	wire logic use_wr = dyn_on && in_wr_window;
	odt_rtt_type next_rtt_sel;

	always_comb begin
		next_rtt_sel = ODT_RTT_OFF;
		if (term_gate) begin
			if (use_wr) begin
				next_rtt_sel = ODT_RTT_WR;
			end else if (nom_code != 3'h0) begin
				next_rtt_sel = ODT_RTT_NOM;
			end else begin
				next_rtt_sel = ODT_RTT_OFF;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtt_sel <= ODT_RTT_OFF;
			term_state <= 1'b0;
			rtt_nom_code <= 3'h0;
			rtt_wr_code <= 2'h0;
			sync_mode <= 1'b1;
			dyn_en <= 1'b0;
		end else begin
			rtt_sel <= next_rtt_sel;
			term_state <= (next_rtt_sel != ODT_RTT_OFF);
			rtt_nom_code <= nom_code;
			rtt_wr_code <= wr_code;
			sync_mode <= sync_now;
			dyn_en <= dyn_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One switch per terminated line: 32 DQ, 2x2 DQS, 2 DM
	// Lanes share one flop; a per-lane copy would only add area
	genvar lane;
	generate
		for (lane = 0; lane < TERM_LANES; lane++) begin : g_lane
			assign term_lane[lane] = term_state;
		end
	endgenerate

	// Loop-off operation relies on the controller keeping termination off
	// and dynamic switching disabled beforehand.
endmodule : odt_device

// file: common/odt_pkg.sv
// Shared constants and types for the termination control link
package odt_pkg;
	// Mode register selectors on the link
	localparam logic [1:0] MR_SEL_0 = 2'h0;
	localparam logic [1:0] MR_SEL_1 = 2'h1;
	localparam logic [1:0] MR_SEL_2 = 2'h2;
	localparam logic [15:0] MR_RESET = 16'h0000;
	// Field positions in the mode registers
	localparam int MR0_DLL_PD_BIT = 12;
	localparam int MR0_CL_LO = 4;
	localparam int MR1_NOM_B0 = 2;
	localparam int MR1_NOM_B1 = 6;
	localparam int MR1_NOM_B2 = 9;
	localparam int MR1_AL_LO = 3;
	localparam int MR2_CWL_LO = 3;
	localparam int MR2_WR_LO = 9;
	localparam int MR2_WR_HI = 10;
	// Latency arithmetic in clocks, and the terminated lane count
	localparam logic [4:0] CWL_BASE = 5'h05;
	localparam logic [4:0] CL_BASE = 5'h04;
	localparam logic [4:0] ODT_LAT_SUB = 5'h02;
	localparam logic [4:0] CWN4_EXTRA = 5'h04;
	localparam logic [4:0] CWN8_EXTRA = 5'h06;
	localparam logic [2:0] ODTH4 = 3'h4;
	localparam logic [2:0] ODTH8 = 3'h6;
	localparam int DELAY_DEPTH = 32;
	localparam logic [5:0] WR_CNT_MAX = 6'h3f;
	localparam int TERM_LANES = 38;
	// Host register map, then the strength select type
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_WANT = 0;
	localparam int CTRL_DLL_OFF = 1;
	localparam int CTRL_SREF = 2;
	localparam int CTRL_CKE = 3;
	localparam int CTRL_RD_BLOCK = 4;
	localparam int CMD_WR = 0;
	localparam int CMD_BC4 = 1;
	localparam int CMD_MRS = 2;
	localparam int CMD_SEL_LO = 4;
	localparam int CMD_ADDR_LO = 16;
	localparam logic [4:0] CTRL_RESET = 5'h08;
	typedef enum logic [2:0] {
		ODT_RTT_OFF = 3'b001,
		ODT_RTT_NOM = 3'b010,
		ODT_RTT_WR = 3'b100
	} odt_rtt_type;
endpackage : odt_pkg

// file: common/odt_link_if.sv
// Command-side link between the memory controller and the termination logic
`timescale 1ns/1ps
interface odt_link_if;
	logic odt;
	logic cke;
	logic sref;
	logic wr_cmd;
	logic wr_bc4;
	logic mrs_valid;
	logic [1:0] mrs_sel;
	logic [15:0] mrs_addr;
	modport device (input odt, input cke, input sref, input wr_cmd, input wr_bc4,
		input mrs_valid, input mrs_sel, input mrs_addr);
	modport host (output odt, output cke, output sref, output wr_cmd, output wr_bc4,
		output mrs_valid, output mrs_sel, output mrs_addr);
endinterface : odt_link_if

// file: hw/odt_delay_line.sv
// Selectable-tap delay line, output registered
`timescale 1ns/1ps
module odt_delay_line (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic din,
	input wire logic [4:0] tap,
	output logic dout
);
	import odt_pkg::*;
	logic [DELAY_DEPTH-1:0] stage;
	wire logic tap_bit = (tap == 5'h00) ? din : stage[tap - 5'h01];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage <= '0;
			dout <= 1'b0;
		end else begin
			stage <= {stage[DELAY_DEPTH-2:0], din};
			dout <= tap_bit;
		end
	end
endmodule : odt_delay_line

// file: hw/odt_host.sv
// Controller end: drives the termination pin and honours hold times
`timescale 1ns/1ps
module odt_host (
	input wire logic core_clk,
	input wire logic arst_n,
	odt_link_if.host link,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	import odt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	logic [4:0] ctrl;
	wire logic ctrl_hit = reg_wr && (reg_addr == REG_CTRL);
	wire logic cmd_hit = reg_wr && (reg_addr == REG_CMD);
	wire logic want = ctrl[CTRL_WANT];
	wire logic dll_off = ctrl[CTRL_DLL_OFF];
	wire logic rd_block = ctrl[CTRL_RD_BLOCK];

	////////////////////////////////////////////////////////////////////////////
	// Pin hold: remaining edges the pin must stay high
	logic [2:0] hold;
	// Hold outranks read blocking and loop-off; software waits on busy
	wire logic next_odt = (want && !rd_block && !dll_off) || (hold != 3'h0);
	wire logic pin_rise = !link.odt && next_odt;
	wire logic wr_go = cmd_hit && reg_wdata[CMD_WR];
	wire logic [2:0] wr_need = (reg_wdata[CMD_BC4] ? ODTH4 : ODTH8) - 3'h1;
	wire logic [2:0] hold_dec = (hold == 3'h0) ? 3'h0 : hold - 3'h1;
	wire logic [2:0] hold_base = pin_rise ? (ODTH4 - 3'h1) : hold_dec;
	wire logic wr_hold = wr_go && next_odt && (wr_need > hold_base);
	wire logic [2:0] next_hold = wr_hold ? wr_need : hold_base;

	// MRS while loop-off forces termination value bits to zero
	wire logic [1:0] mrs_sel_in = reg_wdata[CMD_SEL_LO +: 2];
	logic [15:0] mrs_addr_in;
	always_comb begin
		mrs_addr_in = reg_wdata[CMD_ADDR_LO +: 16];
		if (dll_off && mrs_sel_in == MR_SEL_1) begin
			mrs_addr_in[MR1_NOM_B0] = 1'b0;
			mrs_addr_in[MR1_NOM_B1] = 1'b0;
			mrs_addr_in[MR1_NOM_B2] = 1'b0;
		end
		if (dll_off && mrs_sel_in == MR_SEL_2) begin
			mrs_addr_in[MR2_WR_HI:MR2_WR_LO] = 2'h0;
		end
	end

	wire logic [31:0] status = {29'h0000_0000, hold != 3'h0, link.cke, link.odt};
	wire logic [31:0] rd_mux = (reg_addr == REG_CTRL) ? {27'h000_0000, ctrl} :
		(reg_addr == REG_STATUS) ? status : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= CTRL_RESET;
			hold <= 3'h0;
			link.odt <= 1'b0;
			link.wr_cmd <= 1'b0;
			link.wr_bc4 <= 1'b0;
			link.mrs_valid <= 1'b0;
			link.mrs_sel <= 2'h0;
			link.mrs_addr <= 16'h0000;
			reg_rdata <= 32'h0000_0000;
		end else begin
			if (ctrl_hit) begin
				ctrl <= reg_wdata[4:0];
			end
			hold <= next_hold;
			link.odt <= next_odt;
			link.wr_cmd <= wr_go;
			link.wr_bc4 <= wr_go && reg_wdata[CMD_BC4];
			link.mrs_valid <= cmd_hit && reg_wdata[CMD_MRS];
			if (cmd_hit && reg_wdata[CMD_MRS]) begin
				link.mrs_sel <= mrs_sel_in;
				link.mrs_addr <= mrs_addr_in;
			end
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign link.cke = ctrl[CTRL_CKE];
	assign link.sref = ctrl[CTRL_SREF];
endmodule : odt_host

// file: test/odt_link_sva.sv
// Checker for the termination link and the device answers
`timescale 1ns/1ps
module odt_link_sva (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic odt,
	input wire logic sref,
	input wire logic wr_cmd,
	input wire logic wr_bc4,
	input wire logic mrs_valid,
	input wire logic [1:0] mrs_sel,
	input wire logic [15:0] mrs_addr,
	input wire logic rd_drive,
	input wire odt_pkg::odt_rtt_type rtt_sel
);
	import odt_pkg::*;
	logic [15:0] mr1;
	logic [15:0] mr2;
	// Timing checks only hold for a latency of three clocks
	wire base = mr1[4:3] == 2'h0 && mr2[5:3] == 3'h0;
	wire nom = |{mr1[9], mr1[6], mr1[2]};
	wire dyn = |mr2[10:9];
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mr1 <= MR_RESET;
			mr2 <= MR_RESET;
		end else if (mrs_valid && mrs_sel == MR_SEL_1) begin
			mr1 <= mrs_addr;
		end else if (mrs_valid && mrs_sel == MR_SEL_2) begin
			mr2 <= mrs_addr;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////////////
	property p_hold_rise;
		$rose(odt) |-> odt [*4];
	endproperty
	a_hold_rise: assert property (p_hold_rise) else $error("pin dropped early after rise");
	property p_hold_wr8;
		wr_cmd && odt && !wr_bc4 |-> odt [*6];
	endproperty
	a_hold_wr8: assert property (p_hold_wr8) else $error("pin dropped early after long write");
	property p_hold_wr4;
		wr_cmd && odt && wr_bc4 |-> odt [*4];
	endproperty
	a_hold_wr4: assert property (p_hold_wr4) else $error("pin dropped early after chopped write");
	property p_sref_off;
		sref |=> rtt_sel == ODT_RTT_OFF;
	endproperty
	a_sref_off: assert property (p_sref_off) else $error("termination on in self refresh");
	property p_rd_off;
		rd_drive |=> rtt_sel == ODT_RTT_OFF;
	endproperty
	a_rd_off: assert property (p_rd_off) else $error("termination on while driving");
	property p_low_off;
		(base && !odt) [*5] |-> rtt_sel == ODT_RTT_OFF;
	endproperty
	a_low_off: assert property (p_low_off) else $error("termination on with pin low");
	property p_on_lat;
		$rose(odt) && base && nom ##3 !rd_drive && !sref |=> rtt_sel != ODT_RTT_OFF;
	endproperty
	a_on_lat: assert property (p_on_lat) else $error("termination late after pin rise");
	property p_wr_on;
		wr_cmd && odt && dyn && base ##3 !rd_drive && !sref |=> rtt_sel == ODT_RTT_WR;
	endproperty
	a_wr_on: assert property (p_wr_on) else $error("write strength not selected");
	property p_wr_back8;
		wr_cmd && odt && !wr_bc4 && dyn && nom && base ##6 odt |-> ##3 rtt_sel == ODT_RTT_WR ##1 rtt_sel == ODT_RTT_NOM;
	endproperty
	a_wr_back8: assert property (p_wr_back8) else $error("nominal strength not restored");
	c_bl8: cover property (wr_cmd && odt && !wr_bc4);
	c_bc4: cover property (wr_cmd && odt && wr_bc4);
	c_rd: cover property (rd_drive && odt);
endmodule : odt_link_sva

// file: test/tb_top.sv
// Bench: host and device joined over the link, driven through host registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
	import odt_pkg::*;
	logic core_clk;
	logic arst_n;
	logic rd_drive;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	odt_rtt_type rtt_sel;
	logic [TERM_LANES-1:0] term_lane;
	logic [2:0] rtt_nom_code;
	logic [1:0] rtt_wr_code;
	logic sync_mode;
	logic dyn_en;
	logic [31:0] rd;
	int error_cnt;
	int checks;
	int cyc;
	int n;
	odt_link_if link ();
	odt_host i_odt_host (.core_clk(core_clk), .arst_n(arst_n), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	odt_device i_odt_device (.core_clk(core_clk), .arst_n(arst_n), .link(link), .rd_drive(rd_drive),
		.rtt_sel(rtt_sel), .term_lane(term_lane), .rtt_nom_code(rtt_nom_code), .rtt_wr_code(rtt_wr_code),
		.sync_mode(sync_mode), .dyn_en(dyn_en));
	odt_link_sva i_odt_link_sva (.core_clk(core_clk), .arst_n(arst_n), .odt(link.odt), .sref(link.sref),
		.wr_cmd(link.wr_cmd), .wr_bc4(link.wr_bc4), .mrs_valid(link.mrs_valid), .mrs_sel(link.mrs_sel),
		.mrs_addr(link.mrs_addr), .rd_drive(rd_drive), .rtt_sel(rtt_sel));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick
	// Edges from pin seen high until termination shows; one more than the latency
	task automatic lat(output int k);
		k = 0;
		while (link.odt !== 1'b1 && k < 50) begin
			tick(1);
			k++;
		end
		k = 0;
		while (rtt_sel === ODT_RTT_OFF && k < 50) begin
			tick(1);
			k++;
		end
	endtask : lat
	initial begin
		arst_n = 1'b0;
		rd_drive = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tick(1);
		`CHK("rtt_sel", ODT_RTT_OFF, rtt_sel)
		`CHK("sync_mode", 1'b1, sync_mode)
		@(posedge core_clk);
		arst_n <= 1'b1;
		reg_read(8'h0c, rd);
		`CHK("unmapped", 32'h0000_0000, rd)
		$display("test reset done");
		reg_write(REG_CMD, 32'h0204_0014);
		reg_write(REG_CMD, 32'h0400_0024);
		tick(3);
		`CHK("rtt_nom_code", 3'h5, rtt_nom_code)
		`CHK("rtt_wr_code", 2'h2, rtt_wr_code)
		`CHK("dyn_en", 1'b1, dyn_en)
		$display("test mode set done");
		reg_write(REG_CTRL, 32'h0000_0009);
		lat(n);
		`CHK("on latency", int'(CWL_BASE) - int'(ODT_LAT_SUB) + 1, n)
		`CHK("term_lane", {TERM_LANES{1'b1}}, term_lane)
		`CHK("rtt_sel", ODT_RTT_NOM, rtt_sel)
		$display("test pin on done");
		reg_write(REG_CMD, 32'h0000_0001);
		tick(5);
		`CHK("rtt_sel", ODT_RTT_WR, rtt_sel)
		tick(6);
		`CHK("rtt_sel", ODT_RTT_NOM, rtt_sel)
		reg_write(REG_CMD, 32'h0000_0003);
		tick(5);
		`CHK("rtt_sel", ODT_RTT_WR, rtt_sel)
		tick(3);
		`CHK("rtt_sel", ODT_RTT_NOM, rtt_sel)
		$display("test writes done");
		@(posedge core_clk);
		rd_drive <= 1'b1;
		tick(2);
		`CHK("rtt_sel", ODT_RTT_OFF, rtt_sel)
		@(posedge core_clk);
		rd_drive <= 1'b0;
		tick(2);
		`CHK("rtt_sel", ODT_RTT_NOM, rtt_sel)
		reg_write(REG_CTRL, 32'h0000_000d);
		tick(2);
		`CHK("rtt_sel", ODT_RTT_OFF, rtt_sel)
		reg_write(REG_CTRL, 32'h0000_0008);
		tick(10);
		`CHK("rtt_sel", ODT_RTT_OFF, rtt_sel)
		// Set read blocking right after the rise; the hold must keep the pin up
		reg_write(REG_CTRL, 32'h0000_0009);
		reg_write(REG_CTRL, 32'h0000_0019);
		reg_read(REG_STATUS, rd);
		`CHK("status", 32'h0000_0007, rd)
		tick(10);
		`CHK("odt", 1'b0, link.odt)
		$display("test off cases done");
		reg_write(REG_CMD, 32'h020c_0014);
		tick(3);
		reg_write(REG_CTRL, 32'h0000_0009);
		lat(n);
		`CHK("al latency", int'(CWL_BASE) + int'(CL_BASE) - int'(ODT_LAT_SUB), n)
		reg_write(REG_CTRL, 32'h0000_0008);
		tick(12);
		// Clock enable low with slow-exit setting: frozen loop, no additive latency
		reg_write(REG_CTRL, 32'h0000_0001);
		lat(n);
		`CHK("frozen latency", int'(CWL_BASE) - int'(ODT_LAT_SUB) + 1, n)
		`CHK("sync_mode", 1'b0, sync_mode)
		reg_write(REG_CTRL, 32'h0000_0008);
		tick(12);
		reg_write(REG_CMD, 32'h0000_0014);
		reg_write(REG_CMD, 32'h0000_0024);
		reg_write(REG_CTRL, 32'h0000_0009);
		tick(12);
		`CHK("rtt_sel", ODT_RTT_OFF, rtt_sel)
		`CHK("dyn_en", 1'b0, dyn_en)
		$display("test latency and disable done");
		reg_write(REG_CTRL, 32'h0000_000b);
		reg_write(REG_CMD, 32'h0204_0014);
		reg_write(REG_CMD, 32'h0400_0024);
		tick(4);
		`CHK("rtt_nom_code", 3'h0, rtt_nom_code)
		`CHK("rtt_wr_code", 2'h0, rtt_wr_code)
		`CHK("odt", 1'b0, link.odt)
		$display("test loop off done");
		wrap_up();
	end
endmodule : tb_top
